// [hw/irq_pulse_dma_power_regs.sv]
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Edge mode holds irq high for pulse-length field clock cycles.
// - Pulse-length field resets to 15 clock cycles, the short default.
// - Edge pulses spaced by at least spacing field minus one microframes of 125 us.
// - Level mode ignores spacing entirely.
// - Spacing zero issues each edge pulse at once.
// - DMA start address is a 16-bit write-only value at 0x344.
// - Power-down register holds 16-bit wake window at bits 31:16, reset 03E8.
// - Low power bits: clock, overcurrent, regulator, bias, battery, pulldowns.
// - After wake event stay awake wake-window times 10 us, then suspend.
// - Wake window zero means never wake, stay suspended.
// - 16-bit bus: window resets 17E8, any write fixes it at 1400.
// - Pulldown bit set connects port pulldowns, clear disconnects.
module irq_pulse_dma_power_regs
  import irq_pwr_pkg::*;
#(
  parameter int PULSE_CNT_W = 16
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_i,
  input  wire logic                   clk_en_i,
  input  wire logic                   bus16_mode_i,
  input  wire logic [11:0]            addr_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  input  wire logic [31:0]            wdata_i,
  output logic      [31:0]            rdata_o,
  input  wire logic                   irq_event_i,
  input  wire logic                   irq_level_mode_i,
  input  wire logic                   irq_level_i,
  input  wire logic                   wake_event_i,
  input  wire logic                   normal_restore_i,
  output logic                        irq_o,
  output logic [DMA_ADDR_W-1:0]       dma_start_addr_o,
  output logic                        suspend_o,
  output logic                        host_core_clock_enable_o,
  output logic                        port1_overcurrent_power_o,
  output logic                        port2_overcurrent_power_o,
  output logic                        port3_overcurrent_power_o,
  output logic                        regulator_power_in_suspend_o,
  output logic                        bias_power_in_suspend_o,
  output logic                        battery_detector_power_off_o,
  output logic                        second_port_pulldown_en_o,
  output logic                        third_port_pulldown_en_o
);

  import irq_pwr_pkg::*;

  typedef enum logic [1:0] {IRQ_IDLE, IRQ_PULSE, IRQ_GAP} irq_state_t;

  logic [31:0]            shaping_q;
  logic [31:0]            pwr_q;
  logic                   wake_written_q;
  logic [PULSE_CNT_W-1:0] pulse_cnt_q;
  logic [SPACING_W-1:0]   gap_cnt_q;
  logic                   pending_q;
  irq_state_t             irq_st_q;
  logic [WAKE_W-1:0]      wake_cnt_q;
  logic                   awake_q;
  logic                   uframe_tick;
  logic                   wake_tick;
  logic                   bus16_meta_q;
  logic                   bus16_q;
  logic [PULSE_CNT_W-1:0] pulse_len;
  logic [SPACING_W-1:0]   spacing;
  logic [WAKE_W-1:0]      wake_window;

  assign pulse_len = shaping_q[PULSE_LSB +: PULSE_CNT_W];
  assign spacing   = shaping_q[SPACING_LSB +: SPACING_W];

  // Wake window as seen by the power logic, 16-bit bus overrides
  assign wake_window = !bus16_q ? pwr_q[WAKE_LSB +: WAKE_W] :
                       wake_written_q ? WAKE_FIXED_16BIT :
                       WAKE_RST_16BIT;

  // Time bases: one microframe and one wake unit
  tick_divider #(.PERIOD(MICROFRAME_CYC), .WIDTH(PRESCALE_W)) u_uframe (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .tick_o    (uframe_tick)
  );

  tick_divider #(.PERIOD(WAKE_UNIT_CYC), .WIDTH(PRESCALE_W)) u_wake (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .tick_o    (wake_tick)
  );

  // Strap is a pin: two flops before the window mux reads it, reset or not
  always_ff @(posedge clk_sys_i) begin
    if (clk_en_i) begin
      bus16_meta_q <= bus16_mode_i;
      bus16_q      <= bus16_meta_q;
    end
  end

  // Register writes; software keeps reserved bits at reset value
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      shaping_q        <= EDGE_IRQ_SHAPING_RST;
      pwr_q            <= POWER_DOWN_RST;
      dma_start_addr_o <= '0;
      wake_written_q   <= 1'b0;
    end else if (clk_en_i && wr_i) begin
      case (addr_i)
        EDGE_IRQ_SHAPING_OFS: shaping_q <= wdata_i;
        DMA_START_ADDRESS_OFS: begin
          dma_start_addr_o <= wdata_i[DMA_ADDR_W-1:0];
        end
        POWER_DOWN_CONTROL_OFS: begin
          pwr_q          <= wdata_i;
          wake_written_q <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Read mux, registered; DMA address reads zero and changes nothing
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else if (clk_en_i && rd_i) begin
      case (addr_i)
        EDGE_IRQ_SHAPING_OFS:   rdata_o <= shaping_q;
        POWER_DOWN_CONTROL_OFS: begin
          rdata_o <= {wake_window, pwr_q[WAKE_LSB-1:0]};
        end
        default:                rdata_o <= '0;
      endcase
    end
  end

  // Edge pulse shaper with minimum spacing and a pending event
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_st_q    <= IRQ_IDLE;
      irq_o       <= 1'b0;
      pulse_cnt_q <= '0;
      gap_cnt_q   <= '0;
      pending_q   <= 1'b0;
    end else if (clk_en_i) begin
      if (irq_level_mode_i) begin
        // Level mode passes the source straight on, no spacing
        irq_o     <= irq_level_i;
        irq_st_q  <= IRQ_IDLE;
        pending_q <= 1'b0;
      end else begin
        case (irq_st_q)
          IRQ_IDLE: begin
            if ((irq_event_i || pending_q) && pulse_len != '0) begin
              irq_o       <= 1'b1;
              pulse_cnt_q <= pulse_len - 1'b1;
              pending_q   <= 1'b0;
              irq_st_q    <= IRQ_PULSE;
            end
          end
          IRQ_PULSE: begin
            if (irq_event_i) begin
              pending_q <= 1'b1;
            end
            if (pulse_cnt_q == '0) begin
              irq_o     <= 1'b0;
              gap_cnt_q <= spacing;
              irq_st_q  <= (spacing == '0) ? IRQ_IDLE : IRQ_GAP;
            end else begin
              pulse_cnt_q <= pulse_cnt_q - 1'b1;
            end
          end
          IRQ_GAP: begin
            if (irq_event_i) begin
              pending_q <= 1'b1;
            end
            // Counting whole ticks gives at least spacing-1 full frames
            if (uframe_tick) begin
              if (gap_cnt_q <= SPACING_W'(1)) begin
                irq_st_q <= IRQ_IDLE;
              end else begin
                gap_cnt_q <= gap_cnt_q - 1'b1;
              end
            end
          end
          default: irq_st_q <= IRQ_IDLE;
        endcase
      end
    end
  end

  // Wake window: awake for window count of 10 us units, then suspend
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      awake_q    <= 1'b0;
      wake_cnt_q <= '0;
      suspend_o  <= 1'b1;
    end else if (clk_en_i) begin
      if (normal_restore_i) begin
        awake_q   <= 1'b0;
        suspend_o <= 1'b0;
      end else if (wake_event_i && wake_window != '0) begin
        awake_q    <= 1'b1;
        wake_cnt_q <= wake_window;
        suspend_o  <= 1'b0;
      end else if (wake_event_i && suspend_o) begin
        suspend_o <= 1'b1;
      end else if (awake_q && wake_tick) begin
        if (wake_cnt_q <= WAKE_W'(1)) begin
          awake_q   <= 1'b0;
          suspend_o <= 1'b1;
        end else begin
          wake_cnt_q <= wake_cnt_q - 1'b1;
        end
      end
    end
  end

  // Power enables, registered copies of control bits
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      host_core_clock_enable_o     <= POWER_DOWN_RST[PD_CLK_BIT];
      port1_overcurrent_power_o    <= POWER_DOWN_RST[PD_OC1_BIT];
      port2_overcurrent_power_o    <= POWER_DOWN_RST[PD_OC2_BIT];
      port3_overcurrent_power_o    <= POWER_DOWN_RST[PD_OC3_BIT];
      regulator_power_in_suspend_o <= POWER_DOWN_RST[PD_VREG_BIT];
      bias_power_in_suspend_o      <= POWER_DOWN_RST[PD_BIAS_BIT];
      battery_detector_power_off_o <= POWER_DOWN_RST[PD_VBAT_BIT];
      second_port_pulldown_en_o    <= POWER_DOWN_RST[PD_PORT2_BIT];
      third_port_pulldown_en_o     <= POWER_DOWN_RST[PD_PORT3_BIT];
    end else if (clk_en_i) begin
      host_core_clock_enable_o     <= pwr_q[PD_CLK_BIT];
      port1_overcurrent_power_o    <= pwr_q[PD_OC1_BIT];
      port2_overcurrent_power_o    <= pwr_q[PD_OC2_BIT];
      port3_overcurrent_power_o    <= pwr_q[PD_OC3_BIT];
      regulator_power_in_suspend_o <= pwr_q[PD_VREG_BIT];
      bias_power_in_suspend_o      <= pwr_q[PD_BIAS_BIT];
      battery_detector_power_off_o <= pwr_q[PD_VBAT_BIT];
      second_port_pulldown_en_o    <= pwr_q[PD_PORT2_BIT];
      third_port_pulldown_en_o     <= pwr_q[PD_PORT3_BIT];
    end
  end

endmodule

`default_nettype wire

// [pkg/irq_pwr_pkg.sv]
`default_nettype none

package irq_pwr_pkg;

  // Register byte offsets
  localparam logic [11:0] EDGE_IRQ_SHAPING_OFS  = 12'h340;
  localparam logic [11:0] DMA_START_ADDRESS_OFS = 12'h344;
  localparam logic [11:0] POWER_DOWN_CONTROL_OFS = 12'h354;

  // Edge shaping register fields
  localparam int PULSE_LSB   = 0;
  localparam int PULSE_W     = 16;
  localparam int SPACING_LSB = 24;
  localparam int SPACING_W   = 8;
  localparam logic [31:0] EDGE_IRQ_SHAPING_RST = 32'h0000_000F;

  // DMA address field
  localparam int DMA_ADDR_W = 16;

  // Power-down control fields
  localparam int WAKE_LSB      = 16;
  localparam int WAKE_W        = 16;
  localparam int PD_CLK_BIT    = 0;
  localparam int PD_OC1_BIT    = 1;
  localparam int PD_OC2_BIT    = 2;
  localparam int PD_OC3_BIT    = 3;
  localparam int PD_VREG_BIT   = 4;
  localparam int PD_BIAS_BIT   = 5;
  localparam int PD_VBAT_BIT   = 10;
  localparam int PD_PORT2_BIT  = 11;
  localparam int PD_PORT3_BIT  = 12;
  localparam logic [31:0] POWER_DOWN_RST       = 32'h03E8_1BA0;
  localparam logic [15:0] WAKE_RST_16BIT       = 16'h17E8;
  localparam logic [15:0] WAKE_FIXED_16BIT     = 16'h1400;

  // Timing: clock 50 MHz
  localparam int CLK_PERIOD_NS    = 20;
  localparam int MICROFRAME_NS    = 125000;
  localparam int MICROFRAME_CYC   = MICROFRAME_NS / CLK_PERIOD_NS;
  localparam int WAKE_UNIT_NS     = 10000;
  localparam int WAKE_UNIT_CYC    = WAKE_UNIT_NS / CLK_PERIOD_NS;
  localparam int PRESCALE_W       = 13;

endpackage

`default_nettype wire

// [hw/tick_divider.sv]
`timescale 1ns/1ps
`default_nettype none

// Free-running divider giving a one-cycle tick every PERIOD enabled cycles
module tick_divider #(
  parameter int PERIOD = 6250,
  parameter int WIDTH  = 13
) (
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  output logic      tick_o
);

  logic [WIDTH-1:0] cnt_q;

  // Wraps at PERIOD-1 and pulses the tick on the wrap
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (clk_en_i) begin
      if (cnt_q == WIDTH'(PERIOD - 1)) begin
        cnt_q  <= '0;
        tick_o <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + 1'b1;
        tick_o <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// [bench/irq_regs_props.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_regs_props
  import irq_pwr_pkg::*;
(
  input wire logic                  clk_sys_i,
  input wire logic                  reset_i,
  input wire logic                  bus16_mode_i,
  input wire logic [11:0]           addr_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire logic [31:0]           wdata_i,
  input wire logic [31:0]           rdata_o,
  input wire logic                  irq_event_i,
  input wire logic                  irq_level_mode_i,
  input wire logic                  irq_level_i,
  input wire logic                  wake_event_i,
  input wire logic                  irq_o,
  input wire logic [DMA_ADDR_W-1:0] dma_start_addr_o,
  input wire logic                  suspend_o,
  input wire logic                  bias_power_in_suspend_o,
  input wire logic                  second_port_pulldown_en_o
);
  logic [15:0] plen_q, wk_q, hi_q;
  logic [7:0]  sp_q;
  logic [31:0] lo_q;
  // Shaping shadow; a new setting saturates the gap count so the
  // first pulse under it is never judged by the old spacing
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || (wr_i && addr_i == 12'h340)) begin
      plen_q <= reset_i ? 16'h000F : wdata_i[15:0];
      sp_q <= reset_i ? 8'h00 : wdata_i[31:24];
      lo_q <= '1;
    end else if (irq_o) begin
      lo_q <= '0;
    end else if (lo_q != '1) begin
      lo_q <= lo_q + 1;
    end
  end
  // Pulse high time and wake window shadow
  always_ff @(posedge clk_sys_i) begin
    hi_q <= irq_o ? hi_q + 16'h1 : 16'h0;
    if (reset_i)
      wk_q <= 16'h03E8;
    else if (wr_i && addr_i == 12'h354)
      wk_q <= wdata_i[31:16];
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence s_pd_wr;
    wr_i && addr_i == 12'h354;
  endsequence
  sequence s_wake_ask;
    wake_event_i && suspend_o && !bus16_mode_i;
  endsequence
  a_reset_values:
    assert property ($fell(reset_i) |-> suspend_o && !irq_o
      && bias_power_in_suspend_o && second_port_pulldown_en_o)
    else $error("Outputs wrong after reset");
  a_dma_write:
    assert property (wr_i && addr_i == 12'h344
      |=> dma_start_addr_o == $past(wdata_i[15:0]))
    else $error("DMA address not taken");
  a_dma_hidden:
    assert property (rd_i && addr_i == 12'h344 |=> rdata_o == '0)
    else $error("DMA address readable");
  a_pulse_len:
    assert property ($fell(irq_o) && !irq_level_mode_i |-> hi_q == plen_q)
    else $error("Edge pulse length wrong");
  a_event_now:
    assert property (irq_event_i && !irq_o && !irq_level_mode_i
      && sp_q == 8'h00 && plen_q != 16'h0 |=> irq_o)
    else $error("Edge pulse delayed");
  a_spacing_gap:
    assert property ($rose(irq_o) && !irq_level_mode_i && sp_q != 8'h00
      |-> lo_q >= (sp_q - 1) * MICROFRAME_CYC)
    else $error("Edge pulses too close");
  a_level_follow:
    assert property (irq_level_mode_i && $past(irq_level_mode_i)
      |-> irq_o == $past(irq_level_i))
    else $error("Level irq not followed");
  a_wake_exit:
    assert property (s_wake_ask ##0 wk_q != 16'h0 |=> !suspend_o)
    else $error("Wake event ignored");
  a_wake_never:
    assert property (s_wake_ask ##0 wk_q == 16'h0 |=> suspend_o [*4])
    else $error("Woke with zero window");
  a_pd_update:
    assert property (s_pd_wr |-> ##2
      second_port_pulldown_en_o == $past(wdata_i[11], 2))
    else $error("Pulldown enable stale");
endmodule
bind irq_pulse_dma_power_regs irq_regs_props u_props (
  .clk_sys_i                 (clk_sys_i),
  .reset_i                   (reset_i),
  .bus16_mode_i              (bus16_mode_i),
  .addr_i                    (addr_i),
  .wr_i                      (wr_i),
  .rd_i                      (rd_i),
  .wdata_i                   (wdata_i),
  .rdata_o                   (rdata_o),
  .irq_event_i               (irq_event_i),
  .irq_level_mode_i          (irq_level_mode_i),
  .irq_level_i               (irq_level_i),
  .wake_event_i              (wake_event_i),
  .irq_o                     (irq_o),
  .dma_start_addr_o          (dma_start_addr_o),
  .suspend_o                 (suspend_o),
  .bias_power_in_suspend_o   (bias_power_in_suspend_o),
  .second_port_pulldown_en_o (second_port_pulldown_en_o)
);
`default_nettype wire

// [bench/cpu_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  input  wire logic        clk_sys_i,
  input  wire logic [31:0] rdata_i,
  output logic      [11:0] addr_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [31:0] wdata_o
);
  // Bus idle at start
  initial begin
    addr_o = 12'hFFF;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 32'h0;
  end
  // Data is inverted after the strobe so a stale value never helps
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // Read data is registered, so it is taken just after the strobe edge
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

// [bench/irq_pulse_dma_power_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_pulse_dma_power_regs_tb_top;
  import irq_pwr_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        clk_en_i = 1'b1;
  logic        bus16_mode_i = 1'b0;
  logic        irq_level_mode_i = 1'b0;
  logic        irq_level_i = 1'b0;
  logic [2:0]  sv = 3'h0;
  logic        wr_i, rd_i, irq_o, suspend_o;
  logic [11:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [15:0] dma_start_addr_o;
  wire  [8:0]  en;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          hi, lo;
  wire         irq_event_i = sv[0];
  wire         wake_event_i = sv[1];
  wire         normal_restore_i = sv[2];
  // 50 MHz clock
  always #10 clk_sys_i = ~clk_sys_i;
  irq_pulse_dma_power_regs uut (
    .clk_sys_i, .reset_i, .clk_en_i, .bus16_mode_i, .addr_i, .wr_i, .rd_i,
    .wdata_i, .rdata_o, .irq_event_i, .irq_level_mode_i, .irq_level_i,
    .wake_event_i, .normal_restore_i, .irq_o, .dma_start_addr_o, .suspend_o,
    .host_core_clock_enable_o(en[0]), .port1_overcurrent_power_o(en[1]),
    .port2_overcurrent_power_o(en[2]), .port3_overcurrent_power_o(en[3]),
    .regulator_power_in_suspend_o(en[4]), .bias_power_in_suspend_o(en[5]),
    .battery_detector_power_off_o(en[6]), .second_port_pulldown_en_o(en[7]),
    .third_port_pulldown_en_o(en[8])
  );
  cpu_bus_model u_cpu (
    .clk_sys_i, .rdata_i(rdata_o), .addr_o(addr_i), .wr_o(wr_i), .rd_o(rd_i),
    .wdata_o(wdata_i)
  );
  task automatic cmp(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_cmp(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    u_cpu.rd_reg(a, d);
    cmp("rdata", e, d);
  endtask
  // One-cycle pulse on event, wake or restore
  task automatic strobe(input logic [2:0] m);
    @(posedge clk_sys_i);
    sv <= m;
    @(posedge clk_sys_i);
    sv <= 3'h0;
  endtask
  // Cycles until irq rises, then cycles it stays high; both bounded
  task automatic pulse();
    hi = 0;
    lo = 0;
    #1;
    while (irq_o !== 1'b1 && lo < 20000) begin
      @(posedge clk_sys_i);
      #1 lo++;
    end
    while (irq_o === 1'b1 && hi < 70000) begin
      @(posedge clk_sys_i);
      #1 hi++;
    end
  endtask
  task automatic do_reset();
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog well beyond the expected 14k cycles
  initial begin
    #1000000;
    error_cnt++;
    results();
  end
  initial begin
    do_reset();
    rd_cmp(12'h340, 32'h0000_000F);
    rd_cmp(12'h354, 32'h03E8_1BA0);
    rd_cmp(12'h348, 32'h0);
    cmp("enables", 32'h1A0, en);
    $display("test done: reset values");
    u_cpu.wr_reg(12'h344, 32'h0000_ABCD);
    #1 cmp("dma", 32'hABCD, dma_start_addr_o);
    rd_cmp(12'h344, 32'h0);
    cmp("dma", 32'hABCD, dma_start_addr_o);
    $display("test done: dma address");
    u_cpu.wr_reg(12'h354, 32'h0002_1BA0);
    strobe(3'h2);
    #1 cmp("suspend", 32'h0, suspend_o);
    repeat (300) @(posedge clk_sys_i);
    #1 cmp("suspend", 32'h0, suspend_o);
    repeat (800) @(posedge clk_sys_i);
    #1 cmp("suspend", 32'h1, suspend_o);
    u_cpu.wr_reg(12'h354, 32'h0000_079F);
    strobe(3'h2);
    repeat (3) @(posedge clk_sys_i);
    #1 cmp("suspend", 32'h1, suspend_o);
    cmp("enables", 32'h05F, en);
    strobe(3'h4);
    #1 cmp("suspend", 32'h0, suspend_o);
    $display("test done: power control");
    @(posedge clk_sys_i);
    bus16_mode_i <= 1'b1;
    // Strap passes two flops before the window mux sees it
    repeat (2) @(posedge clk_sys_i);
    rd_cmp(12'h354, 32'h1400_079F);
    @(posedge clk_sys_i);
    do_reset();
    rd_cmp(12'h354, 32'h17E8_1BA0);
    $display("test done: narrow bus window");
    strobe(3'h1);
    pulse();
    cmp("pulse", 32'hF, hi);
    u_cpu.wr_reg(12'h340, 32'h0000_0006);
    strobe(3'h1);
    pulse();
    cmp("pulse", 32'h6, hi);
    cmp("delay", 32'h0, lo);
    u_cpu.wr_reg(12'h340, 32'h0200_0006);
    strobe(3'h1);
    pulse();
    strobe(3'h1);
    strobe(3'h1);
    pulse();
    cmp("pulse", 32'h6, hi);
    cmp("gap", 32'h1, lo >= 6240 && lo <= 12600);
    @(posedge clk_sys_i);
    irq_level_mode_i <= 1'b1;
    irq_level_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 cmp("level", 32'h1, irq_o);
    @(posedge clk_sys_i);
    irq_level_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 cmp("level", 32'h0, irq_o);
    $display("test done: interrupt shaping");
    results();
  end
endmodule
`default_nettype wire
